// [hdl/stt_pkg.sv]
package stt_pkg;

  localparam int STT_AW = 12;
  localparam int STT_DW = 32;
  localparam int STT_CW = 24;

  // register offsets within the private peripheral window
  localparam logic [11:0] STT_OFS_CTRL = 12'h010;
  localparam logic [11:0] STT_OFS_RELOAD = 12'h014;
  localparam logic [11:0] STT_OFS_CURRENT = 12'h018;
  localparam logic [11:0] STT_OFS_CALIB = 12'h01C;

  // control and status field positions
  localparam int STT_BIT_ENABLE = 0;
  localparam int STT_BIT_IRQ_EN = 1;
  localparam int STT_BIT_CLK_SEL = 2;
  localparam int STT_BIT_ZERO_FLAG = 16;

  // values after reset
  localparam logic [23:0] STT_RST_RELOAD = 24'h000000;
  localparam logic [23:0] STT_RST_CURRENT = 24'h000000;
  localparam logic [23:0] STT_RST_CALIB = 24'h000004;
  localparam logic [2:0] STT_RST_CTRL = 3'h0;

  // halved tick: one enable pulse every this many system cycles
  localparam int STT_HALF_DIV = 2;

  typedef struct packed {
    logic enable;
    logic irq_enable;
    logic clock_select;
  } stt_ctrl_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } stt_bus_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } stt_bus_rsp_t;

endpackage : stt_pkg

// [hdl/stt_timer.sv]
// Function
// - A 24-bit down counter reloads from the 24-bit reload field each time it reaches zero.
// - The counter decrements only while control bit 0 is one and holds while it is zero.
// - With control bit 1 set, reaching zero raises the tick interrupt; with it clear, never.
// - Control bit 2 at one counts on the system clock, at zero on the system clock halved.
// - Control bit 16 reads one if zero was reached since the last read, and a read clears it.
// - Any write to the current value register clears the counter, and clears the zero-reached flag unless zero is reached in that cycle.
// - Reading the current value register returns the live counter in its low 24 bits.
// - The calibration field mirrors an external configuration value whose reset value is 4.
// - Reset clears enable, interrupt enable, clock select, the flag, reload and counter.
// - The tick interrupt leaves on its own dedicated output, not a shared line.
`timescale 1ns/1ns
`default_nettype none

module stt_timer
  import stt_pkg::*;
#(
  parameter int CNT_W = STT_CW
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // register port
  input wire stt_bus_req_t i_bus,
  output var stt_bus_rsp_t o_bus,
  // calibration source from system configuration
  input wire logic [23:0] i_calibration_source_value,
  // dedicated tick exception request
  output logic o_tick_irq
);

  if (CNT_W != STT_CW) begin : g_width_check
    $error("stt_timer supports only a 24-bit counter");
  end

  stt_ctrl_t ctrl_q;
  logic [23:0] reload_q;
  logic [23:0] count_q;
  logic [23:0] count_d;
  logic zero_flag_q;
  logic half_en_q;
  logic tick_en;
  logic hit_zero;
  logic wr_ctrl;
  logic wr_reload;
  logic wr_current;
  logic rd_ctrl;
  logic mapped;
  logic [31:0] rdata_d;
  logic [23:0] calib_q;
  logic [1:0] tick_gap_q;

  // address decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_reload = 1'b0;
    wr_current = 1'b0;
    rd_ctrl = 1'b0;
    mapped = 1'b1;
    rdata_d = 32'h00000000;
    if (i_bus.addr == STT_OFS_CTRL) begin
      wr_ctrl = i_bus.req & i_bus.wr;
      rd_ctrl = i_bus.req & ~i_bus.wr;
      rdata_d[STT_BIT_ENABLE] = ctrl_q.enable;
      rdata_d[STT_BIT_IRQ_EN] = ctrl_q.irq_enable;
      rdata_d[STT_BIT_CLK_SEL] = ctrl_q.clock_select;
      rdata_d[STT_BIT_ZERO_FLAG] = zero_flag_q;
    end else if (i_bus.addr == STT_OFS_RELOAD) begin
      wr_reload = i_bus.req & i_bus.wr;
      rdata_d[23:0] = reload_q;
    end else if (i_bus.addr == STT_OFS_CURRENT) begin
      wr_current = i_bus.req & i_bus.wr;
      rdata_d[23:0] = count_q;
    end else if (i_bus.addr == STT_OFS_CALIB) begin
      rdata_d[23:0] = calib_q;
    end else begin
      mapped = 1'b0;
    end
  end

  // bus answer one cycle after the request; reserved bits read zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_bus <= '0;
    end else begin
      o_bus.ack <= i_bus.req;
      o_bus.err <= i_bus.req & ~mapped;
      o_bus.rdata <= (i_bus.req & ~i_bus.wr) ? rdata_d : 32'h00000000;
    end
  end

  // calibration is not stored by software; register the external value
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      calib_q <= STT_RST_CALIB;
    end else begin
      calib_q <= i_calibration_source_value;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_q <= stt_ctrl_t'(STT_RST_CTRL);
    end else if (wr_ctrl) begin
      ctrl_q.enable <= i_bus.wdata[STT_BIT_ENABLE];
      ctrl_q.irq_enable <= i_bus.wdata[STT_BIT_IRQ_EN];
      ctrl_q.clock_select <= i_bus.wdata[STT_BIT_CLK_SEL];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      reload_q <= STT_RST_RELOAD;
    end else if (wr_reload) begin
      reload_q <= i_bus.wdata[23:0];
    end
  end

  // divide-by-two strobe; free running so no derived clock is needed
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      half_en_q <= 1'b0;
    end else begin
      half_en_q <= ~half_en_q;
    end
  end

  // checker helper: cycles since the last tick while counting is on
  // saturates so a stuck strobe cannot wrap back into the legal range
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tick_gap_q <= 2'h0;
    end else if (tick_en || !ctrl_q.enable) begin
      tick_gap_q <= 2'h0;
    end else if (tick_gap_q != 2'h3) begin
      tick_gap_q <= tick_gap_q + 2'h1;
    end
  end

  assign tick_en = ctrl_q.enable & (ctrl_q.clock_select | half_en_q);
  // reaching zero: a decrement from one; a counter held at zero just reloads
  assign hit_zero = tick_en & (count_q == 24'h000001);

  always_comb begin
    count_d = count_q;
    if (tick_en) begin
      if (count_q == 24'h000000) begin
        count_d = reload_q;
      end else begin
        count_d = count_q - 24'h000001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_q <= STT_RST_CURRENT;
    end else if (wr_current) begin
      count_q <= 24'h000000;
    end else begin
      count_q <= count_d;
    end
  end

  // a zero event in the cycle of a clear still sets the flag
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      zero_flag_q <= 1'b0;
    end else if (hit_zero) begin
      zero_flag_q <= 1'b1;
    end else if (rd_ctrl | wr_current) begin
      zero_flag_q <= 1'b0;
    end
  end

  // one-cycle request on its own exception line
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_tick_irq <= 1'b0;
    end else begin
      o_tick_irq <= hit_zero & ctrl_q.irq_enable;
    end
  end

  // checks
  reload_at_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (tick_en && count_q == 24'h000000 && !wr_current) |=> count_q == $past(reload_q))
    else $error("counter did not reload at zero");

  hold_when_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (!ctrl_q.enable && !wr_current) |=> count_q == $past(count_q))
    else $error("counter moved while disabled");

  irq_gated_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_tick_irq |-> $past(ctrl_q.irq_enable) && $past(count_q) == 24'h000001)
    else $error("interrupt without enabled zero event");

  irq_raised_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (hit_zero && ctrl_q.irq_enable) |=> o_tick_irq)
    else $error("enabled zero event lost its interrupt");

  half_rate_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (ctrl_q.enable && !ctrl_q.clock_select && tick_en && !wr_ctrl) |=> !tick_en)
    else $error("halved rate ticked twice in a row");

  full_rate_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (ctrl_q.enable && ctrl_q.clock_select) |-> tick_en)
    else $error("full rate missed a tick");

  flag_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
    hit_zero |=> zero_flag_q)
    else $error("zero flag not set");

  flag_read_clr_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (rd_ctrl && !hit_zero) |=> !zero_flag_q)
    else $error("zero flag survived a read");

  current_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr_current && !hit_zero) |=> count_q == 24'h000000 && !zero_flag_q)
    else $error("current write did not clear");

  live_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_bus.req && !i_bus.wr && i_bus.addr == STT_OFS_CURRENT)
      |=> o_bus.rdata == {8'h00, $past(count_q)})
    else $error("current read not live");

  calib_mirror_a: assert property (@(posedge i_clk) disable iff (i_reset)
    1'b1 |=> calib_q == $past(i_calibration_source_value))
    else $error("calibration not mirrored");

  reset_values_a: assert property (@(posedge i_clk)
    $past(i_reset) |-> count_q == 24'h000000 && reload_q == 24'h000000
      && !zero_flag_q && calib_q == STT_RST_CALIB
      && ctrl_q == stt_ctrl_t'(STT_RST_CTRL))
    else $error("bad state after reset");

  // counter path
  decrement_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (tick_en && count_q != 24'h000000 && !wr_current)
      |=> count_q == $past(count_q) - 24'h000001)
    else $error("counter did not step down by one");

  reload_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_reload
      |=> reload_q == $past(i_bus.wdata[23:0]))
    else $error("reload write lost");

  no_event_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !ctrl_q.enable
      |-> !hit_zero)
    else $error("zero event while disabled");

  // the strobe toggles freely, so a missed tick means a broken divider
  half_gap_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (ctrl_q.enable && !ctrl_q.clock_select && !tick_en && !wr_ctrl)
      |=> tick_en)
    else $error("halved rate skipped a tick");

  tick_gap_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ctrl_q.enable
      |-> tick_gap_q < 2'(STT_HALF_DIV))
    else $error("tick gap too long");

  // control register fields
  enable_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_ctrl
      |=> ctrl_q.enable == $past(i_bus.wdata[STT_BIT_ENABLE]))
    else $error("enable bit write lost");

  irq_en_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_ctrl
      |=> ctrl_q.irq_enable == $past(i_bus.wdata[STT_BIT_IRQ_EN]))
    else $error("interrupt enable write lost");

  clk_sel_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_ctrl
      |=> ctrl_q.clock_select == $past(i_bus.wdata[STT_BIT_CLK_SEL]))
    else $error("clock select write lost");

  // interrupt line
  irq_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !ctrl_q.irq_enable
      |=> !o_tick_irq)
    else $error("interrupt while disabled");

  irq_pulse_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_tick_irq
      |=> !o_tick_irq)
    else $error("interrupt wider than one cycle");

  // flag and read answers
  flag_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (zero_flag_q && !rd_ctrl && !wr_current)
      |=> zero_flag_q)
    else $error("zero flag dropped on its own");

  ctrl_readback_a: assert property (@(posedge i_clk) disable iff (i_reset)
    rd_ctrl
      |=> o_bus.rdata[STT_BIT_ZERO_FLAG] == $past(zero_flag_q))
    else $error("flag read back wrong");

  reserved_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    rd_ctrl
      |=> o_bus.rdata[15:3] == 13'h0000 && o_bus.rdata[31:17] == 15'h0000)
    else $error("reserved control bits not zero");

  calib_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_bus.req && !i_bus.wr && i_bus.addr == STT_OFS_CALIB)
      |=> o_bus.rdata == {8'h00, $past(calib_q)})
    else $error("calibration read wrong");

  wrap_cov: cover property (@(posedge i_clk) disable iff (i_reset)
    hit_zero ##[1:4] (tick_en && count_q == 24'h000000));
  irq_cov: cover property (@(posedge i_clk) disable iff (i_reset) o_tick_irq);
  half_cov: cover property (@(posedge i_clk) disable iff (i_reset)
    hit_zero && !ctrl_q.clock_select);
  clash_cov: cover property (@(posedge i_clk) disable iff (i_reset) hit_zero && rd_ctrl);
  clear_cov: cover property (@(posedge i_clk) disable iff (i_reset)
    wr_current && zero_flag_q);

endmodule : stt_timer

`default_nettype wire

// [verification/stt_timer_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module stt_timer_tb;
  import stt_pkg::*;

  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  stt_bus_req_t bus_req = '0;
  stt_bus_rsp_t bus_rsp;
  logic [23:0] cal_src = 24'h0ABCDE;
  logic tick_irq;
  int err_count = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic [31:0] rd2;
  int gap;
  int n;

  always #2 i_clk = ~i_clk;

  stt_timer dut (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_bus(bus_req),
    .o_bus(bus_rsp),
    .i_calibration_source_value(cal_src),
    .o_tick_irq(tick_irq)
  );

  task automatic finish_test;
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // request for one cycle, answer looked at in the cycle it stands
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(negedge i_clk);
    bus_req <= '{req: 1'b1, wr: w, addr: a, wdata: d};
    @(negedge i_clk);
    q = bus_rsp.rdata;
    chk({31'h0, bus_rsp.ack}, 32'h1);
    chk({31'h0, bus_rsp.err}, {31'h0, a > STT_OFS_CALIB});
    bus_req <= '0;
  endtask : acc

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d, rd);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask : rdc

  // cycles between two successive tick pulses, bounded
  task automatic irq_gap(output int g);
    g = 0;
    while (tick_irq !== 1'b1 && g < 200) begin
      @(negedge i_clk);
      g++;
    end
    g = 0;
    do begin
      @(negedge i_clk);
      g++;
    end while (tick_irq !== 1'b1 && g < 200);
  endtask : irq_gap

  initial begin
    #20000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    i_reset = 1'b0;
    rdc(STT_OFS_CTRL, 32'h0);
    rdc(STT_OFS_RELOAD, 32'h0);
    rdc(STT_OFS_CURRENT, 32'h0);
    rdc(STT_OFS_CALIB, 32'h000ABCDE);
    wr(STT_OFS_CALIB, 32'h00000123);
    rdc(STT_OFS_CALIB, 32'h000ABCDE);
    acc(1'b0, 12'h020, 32'h0, rd);
    wr(STT_OFS_RELOAD, 32'h000ABCDE);
    rdc(STT_OFS_RELOAD, 32'h000ABCDE);
    wr(STT_OFS_RELOAD, 32'h00000004);
    rdc(STT_OFS_RELOAD, 32'h00000004);
    wr(STT_OFS_CTRL, 32'h00000006);
    repeat (10) @(negedge i_clk);
    rdc(STT_OFS_CURRENT, 32'h0);
    wr(STT_OFS_CURRENT, 32'h0);
    wr(STT_OFS_CTRL, 32'h00000007);
    irq_gap(gap);
    chk(gap, 32'd5);
    wr(STT_OFS_CTRL, 32'h00000006);
    wr(STT_OFS_CURRENT, 32'h00000055);
    rdc(STT_OFS_CTRL, 32'h00000006);
    rdc(STT_OFS_CURRENT, 32'h0);
    wr(STT_OFS_CTRL, 32'h00000007);
    irq_gap(gap);
    wr(STT_OFS_CTRL, 32'h00000006);
    rdc(STT_OFS_CTRL, 32'h00010006);
    rdc(STT_OFS_CTRL, 32'h00000006);
    wr(STT_OFS_CTRL, 32'h00000003);
    irq_gap(gap);
    chk(gap, 32'd10);
    wr(STT_OFS_CTRL, 32'h00000005);
    n = 0;
    repeat (30) begin
      @(negedge i_clk);
      if (tick_irq !== 1'b0) n++;
    end
    chk(n, 32'd0);
    rdc(STT_OFS_CTRL, 32'h00010005);
    wr(STT_OFS_RELOAD, 32'h00000100);
    wr(STT_OFS_CURRENT, 32'h0);
    acc(1'b0, STT_OFS_CURRENT, 32'h0, rd);
    acc(1'b0, STT_OFS_CURRENT, 32'h0, rd2);
    chk(rd - rd2, 32'd2);
    chk({8'h0, rd[31:24]}, 32'h0);
    // second reset with the counter running and fields set
    @(negedge i_clk);
    i_reset = 1'b1;
    repeat (3) @(negedge i_clk);
    i_reset = 1'b0;
    rdc(STT_OFS_CTRL, 32'h0);
    rdc(STT_OFS_RELOAD, 32'h0);
    rdc(STT_OFS_CURRENT, 32'h0);
    finish_test();
  end

endmodule : stt_timer_tb

`default_nettype wire
